// *** verilog/dairm_register_map.sv ***
// Upper register map of base region zero: decode, storage and access semantics
`include "dairm_defines.svh"
`default_nettype none
module dairm_register_map import dairm_pkg::*; #(
   parameter int PIN_COUNT    = `DAIRM_PIN_COUNT,
   parameter bit HAS_OUT_CONV = 1'b1
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_b_i,
   // Host access port of base region zero
   input  wire logic [9:0]           bus_addr_i,
   input  wire logic [3:0]           bus_be_i,
   input  wire logic                 bus_wr_i,
   input  wire logic                 bus_rd_i,
   input  wire logic [31:0]          bus_wdata_i,
   output logic      [31:0]          bus_rdata_o,
   output logic                      bus_ack_o,
   // Read-only state from the surrounding logic
   input  wire logic [31:0]          conv2_status_i,
   input  wire logic [31:0]          conv3_status_i,
   input  wire logic [31:0]          conv4_status_i,
   input  wire logic [31:0]          seq_status_i,
   input  wire logic [31:0]          seq_conv_count_i,
   input  wire logic [31:0]          seq_queue_level_i,
   input  wire logic [31:0]          seq_buffer_next_i,
   input  wire logic [31:0]          frame_timer_i,
   // Hardware events and clears
   input  wire logic [31:0]          irq_event_i,
   input  wire logic [31:0]          error_event_i,
   input  wire logic                 seq_start_clear_i,
   // Control outputs and the read/write word select
   output logic                      seq_start_o,
   output logic      [31:0]          seq_control_o,
   output logic      [31:0]          irq_status_o,
   output logic      [31:0]          error_irq_status_o,
   output logic      [31:0]          pin_irq_status_o,
   input  wire logic [9:0]           rw_sel_i,
   output logic      [31:0]          rw_word_o,
   // Digital pins
   input  wire logic [PIN_COUNT-1:0] digital_pin_i,
   output logic      [PIN_COUNT-1:0] digital_pin_o,
   output logic      [PIN_COUNT-1:0] digital_pin_oe_o
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (PIN_COUNT < 1 || PIN_COUNT > 32) begin : g_bad_pin_count
      $error("PIN_COUNT must lie between 1 and 32");
   end

   localparam int MEM_WORDS = `DAIRM_MEM_WORDS;

   // ****************************************************************
   // Helper functions
   // ****************************************************************
   function automatic dairm_access_e access_of(input logic [9:0] off);
      dairm_access_e k;
      k = DAIRM_RSV;
      case (off)
         `DAIRM_OFF_CONV2_DATA_CD, `DAIRM_OFF_CONV2_MODE,
         `DAIRM_OFF_CONV3_CONFIG, `DAIRM_OFF_CONV3_CORR_A, `DAIRM_OFF_CONV3_CORR_B,
         `DAIRM_OFF_CONV3_CORR_C, `DAIRM_OFF_CONV3_CORR_D, `DAIRM_OFF_CONV3_DATA_AB,
         `DAIRM_OFF_CONV3_DATA_CD, `DAIRM_OFF_CONV3_MODE,
         `DAIRM_OFF_CONV4_CONFIG, `DAIRM_OFF_CONV4_CORR_A, `DAIRM_OFF_CONV4_CORR_B,
         `DAIRM_OFF_CONV4_CORR_C, `DAIRM_OFF_CONV4_CORR_D, `DAIRM_OFF_CONV4_DATA_AB,
         `DAIRM_OFF_CONV4_DATA_CD, `DAIRM_OFF_CONV4_MODE,
         `DAIRM_OFF_SEQ_CONV_TOTAL, `DAIRM_OFF_SEQ_BUF_BASE, `DAIRM_OFF_SEQ_BUF_LENGTH,
         `DAIRM_OFF_CONV_CLOCK1, `DAIRM_OFF_CONV_CLOCK2,
         `DAIRM_OFF_FRAME_TRIG_1, `DAIRM_OFF_FRAME_TRIG_2,
         `DAIRM_OFF_SIG_GEN_ENABLE, `DAIRM_OFF_SIG_OUT_DRIVE, `DAIRM_OFF_SIG_SOURCE_SEL,
         `DAIRM_OFF_PIN_DEBOUNCE, `DAIRM_OFF_PIN_OUTPUT, `DAIRM_OFF_PIN_OUTPUT_EN,
         `DAIRM_OFF_IRQ_ENABLE, `DAIRM_OFF_ERR_IRQ_ENABLE,
         `DAIRM_OFF_PIN_RISE_EN, `DAIRM_OFF_PIN_FALL_EN: begin
            k = DAIRM_RW;
         end
         `DAIRM_OFF_CONV2_STATUS, `DAIRM_OFF_CONV3_STATUS, `DAIRM_OFF_CONV4_STATUS,
         `DAIRM_OFF_SEQ_STATUS, `DAIRM_OFF_SEQ_CONV_COUNT, `DAIRM_OFF_SEQ_QUEUE_LEVEL,
         `DAIRM_OFF_SEQ_BUF_NEXT, `DAIRM_OFF_FRAME_TIMER, `DAIRM_OFF_PIN_INPUT: begin
            k = DAIRM_RO;
         end
         `DAIRM_OFF_IRQ_STATUS, `DAIRM_OFF_ERR_IRQ_STATUS, `DAIRM_OFF_PIN_IRQ_STATUS: begin
            k = DAIRM_RC;
         end
         `DAIRM_OFF_SEQ_CONTROL: begin
            k = DAIRM_SEQ;
         end
         default: begin
            k = DAIRM_RSV;
         end
      endcase
      if (!HAS_OUT_CONV && off <= `DAIRM_OFF_SEQ_BUF_NEXT) begin
         k = DAIRM_RSV;
      end
      return k;
   endfunction

   // Storage index of a word offset
   function automatic logic [6:0] index_of(input logic [9:0] off);
      logic [7:0] word;
      word = off[9:2] - `DAIRM_MEM_FIRST_WORD;
      return word[6:0];
   endfunction

   function automatic logic [31:0] be_mask(input logic [3:0] be);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int b = 0; b < 4; b++) begin
         m[b*8 +: 8] = {8{be[b]}};
      end
      return m;
   endfunction

   function automatic logic [31:0] pad_pins(input logic [PIN_COUNT-1:0] v);
      logic [31:0] w;
      w = 32'h0000_0000;
      for (int p = 0; p < PIN_COUNT; p++) begin
         w[p] = v[p];
      end
      return w;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   logic [31:0]          mem_reg [0:MEM_WORDS-1];
   logic [31:0]          irq_status_reg;
   logic [31:0]          err_status_reg;
   logic [31:0]          pin_status_reg;
   logic                 seq_start_reg;
   logic [31:0]          rdata_reg;
   logic                 ack_reg;
   logic [31:0]          rw_word_reg;
   logic [PIN_COUNT-1:0] pin_s1_reg;
   logic [PIN_COUNT-1:0] pin_s2_reg;
   logic [PIN_COUNT-1:0] pin_s3_reg;
   logic [PIN_COUNT-1:0] pin_state_reg;

   // ****************************************************************
   // Decode
   // ****************************************************************
   dairm_access_e        bus_kind;
   dairm_access_e        sel_kind;
   logic [6:0]           bus_idx;
   logic [31:0]          wr_mask;
   logic                 rw_write;
   logic                 rc_write;
   logic [31:0]          clr_bits;
   logic [31:0]          mem_rd;
   logic [31:0]          seq_ctrl_word;

   assign bus_kind = access_of(bus_addr_i);
   assign sel_kind = access_of(rw_sel_i);
   assign bus_idx  = index_of(bus_addr_i);
   assign wr_mask  = be_mask(bus_be_i);
   assign rw_write = bus_wr_i && (bus_kind == DAIRM_RW || bus_kind == DAIRM_SEQ);
   assign rc_write = bus_wr_i && (bus_kind == DAIRM_RC);
   assign clr_bits = bus_wdata_i & wr_mask;
   assign mem_rd   = (bus_kind == DAIRM_RW || bus_kind == DAIRM_SEQ) ? mem_reg[bus_idx]
                                                                     : `DAIRM_RSV_READ;
   assign seq_ctrl_word = mem_reg[index_of(`DAIRM_OFF_SEQ_CONTROL)];

   // ****************************************************************
   // Read/write storage
   // ****************************************************************
   // masked word update
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < MEM_WORDS; i++) begin
            mem_reg[i] <= `DAIRM_RW_RESET;
         end
      end else if (rw_write) begin
         mem_reg[bus_idx] <= (mem_reg[bus_idx] & ~wr_mask) | (bus_wdata_i & wr_mask);
      end
   end

   // ****************************************************************
   // Digital pin input filter
   // ****************************************************************
   logic [PIN_COUNT-1:0] pin_agree;
   logic [PIN_COUNT-1:0] pin_state_next;
   logic [PIN_COUNT-1:0] pin_rise;
   logic [PIN_COUNT-1:0] pin_fall;
   logic [PIN_COUNT-1:0] rise_en;
   logic [PIN_COUNT-1:0] fall_en;
   logic [31:0]          pin_event;

   // Only stages two and three are compared; stage one may be metastable
   assign pin_agree      = ~(pin_s2_reg ^ pin_s3_reg);
   assign pin_state_next = (pin_state_reg & ~pin_agree) | (pin_s2_reg & pin_agree);
   assign pin_rise       = pin_state_next & ~pin_state_reg;
   assign pin_fall       = ~pin_state_next & pin_state_reg;
   assign rise_en        = mem_reg[index_of(`DAIRM_OFF_PIN_RISE_EN)][PIN_COUNT-1:0];
   assign fall_en        = mem_reg[index_of(`DAIRM_OFF_PIN_FALL_EN)][PIN_COUNT-1:0];
   assign pin_event      = pad_pins((pin_rise & rise_en) | (pin_fall & fall_en));

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_s1_reg    <= '0;
         pin_s2_reg    <= '0;
         pin_s3_reg    <= '0;
         pin_state_reg <= '0;
      end else begin
         pin_s1_reg    <= digital_pin_i;
         pin_s2_reg    <= pin_s1_reg;
         pin_s3_reg    <= pin_s2_reg;
         pin_state_reg <= pin_state_next;
      end
   end

   // ****************************************************************
   // Read/clear status and read/set start
   // ****************************************************************
   logic [31:0] irq_status_next;
   logic [31:0] err_status_next;
   logic [31:0] pin_status_next;
   logic        seq_start_next;
   logic        seq_sw_set;

   assign irq_status_next = (irq_status_reg &
                             ~((rc_write && bus_addr_i == `DAIRM_OFF_IRQ_STATUS) ? clr_bits : 32'h0))
                            | irq_event_i;
   assign err_status_next = (err_status_reg &
                             ~((rc_write && bus_addr_i == `DAIRM_OFF_ERR_IRQ_STATUS) ? clr_bits : 32'h0))
                            | error_event_i;
   assign pin_status_next = (pin_status_reg &
                             ~((rc_write && bus_addr_i == `DAIRM_OFF_PIN_IRQ_STATUS) ? clr_bits : 32'h0))
                            | pin_event;
   assign seq_sw_set     = rw_write && bus_kind == DAIRM_SEQ && bus_be_i[0] &&
                           bus_wdata_i[`DAIRM_SEQ_START_BIT];
   assign seq_start_next = (seq_start_reg & ~seq_start_clear_i) | seq_sw_set;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_status_reg <= `DAIRM_STATUS_RESET;
         err_status_reg <= `DAIRM_STATUS_RESET;
         pin_status_reg <= `DAIRM_STATUS_RESET;
         seq_start_reg  <= 1'b0;
      end else begin
         irq_status_reg <= irq_status_next;
         err_status_reg <= err_status_next;
         pin_status_reg <= pin_status_next;
         seq_start_reg  <= HAS_OUT_CONV ? seq_start_next : 1'b0;
      end
   end

   // ****************************************************************
   // Read data selection
   // ****************************************************************
   logic [31:0] ro_rd;
   logic [31:0] rd_word;

   always_comb begin
      ro_rd = `DAIRM_RSV_READ;
      case (bus_addr_i)
         `DAIRM_OFF_CONV2_STATUS:    ro_rd = conv2_status_i;
         `DAIRM_OFF_CONV3_STATUS:    ro_rd = conv3_status_i;
         `DAIRM_OFF_CONV4_STATUS:    ro_rd = conv4_status_i;
         `DAIRM_OFF_SEQ_STATUS:      ro_rd = seq_status_i;
         `DAIRM_OFF_SEQ_CONV_COUNT:  ro_rd = seq_conv_count_i;
         `DAIRM_OFF_SEQ_QUEUE_LEVEL: ro_rd = seq_queue_level_i;
         `DAIRM_OFF_SEQ_BUF_NEXT:    ro_rd = seq_buffer_next_i;
         `DAIRM_OFF_FRAME_TIMER:     ro_rd = frame_timer_i;
         `DAIRM_OFF_PIN_INPUT:       ro_rd = pad_pins(pin_state_reg);
         `DAIRM_OFF_IRQ_STATUS:      ro_rd = irq_status_reg;
         `DAIRM_OFF_ERR_IRQ_STATUS:  ro_rd = err_status_reg;
         `DAIRM_OFF_PIN_IRQ_STATUS:  ro_rd = pin_status_reg;
         default:                    ro_rd = `DAIRM_RSV_READ;
      endcase
   end

   assign rd_word = (bus_kind == DAIRM_RO || bus_kind == DAIRM_RC) ? ro_rd :
                    (bus_kind == DAIRM_SEQ) ? {mem_rd[31:1], seq_start_reg} :
                    mem_rd;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_reg   <= `DAIRM_RSV_READ;
         ack_reg     <= 1'b0;
         rw_word_reg <= `DAIRM_RSV_READ;
      end else begin
         rdata_reg   <= bus_rd_i ? rd_word : rdata_reg;
         ack_reg     <= bus_rd_i | bus_wr_i;
         rw_word_reg <= (sel_kind == DAIRM_RW || sel_kind == DAIRM_SEQ) ?
                        mem_reg[index_of(rw_sel_i)] : `DAIRM_RSV_READ;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign bus_rdata_o        = rdata_reg;
   assign bus_ack_o          = ack_reg;
   assign seq_start_o        = seq_start_reg;
   // Bit 0 is replaced by the start flag, set by software and cleared by seq_start_clear_i
   assign seq_control_o      = HAS_OUT_CONV ? {seq_ctrl_word[31:1], seq_start_reg}
                                            : `DAIRM_RSV_READ;
   assign irq_status_o       = irq_status_reg;
   assign error_irq_status_o = err_status_reg;
   assign pin_irq_status_o   = pin_status_reg;
   assign rw_word_o          = rw_word_reg;
   assign digital_pin_o      = mem_reg[index_of(`DAIRM_OFF_PIN_OUTPUT)][PIN_COUNT-1:0];
   assign digital_pin_oe_o   = mem_reg[index_of(`DAIRM_OFF_PIN_OUTPUT_EN)][PIN_COUNT-1:0];

endmodule // dairm_register_map
`default_nettype wire

// *** verilog/dairm_defines.svh ***
// Offsets, field positions, reset values and sizes of the upper register map
`ifndef DAIRM_DEFINES_SVH
`define DAIRM_DEFINES_SVH

// ****************************************************************
// Register offsets inside base region zero
// ****************************************************************
`define DAIRM_OFF_CONV2_DATA_CD     10'h1b4
`define DAIRM_OFF_CONV2_STATUS      10'h1b8
`define DAIRM_OFF_CONV2_MODE        10'h1bc
`define DAIRM_OFF_CONV3_CONFIG      10'h1c8
`define DAIRM_OFF_CONV3_CORR_A      10'h1d0
`define DAIRM_OFF_CONV3_CORR_B      10'h1d4
`define DAIRM_OFF_CONV3_CORR_C      10'h1d8
`define DAIRM_OFF_CONV3_CORR_D      10'h1dc
`define DAIRM_OFF_CONV3_DATA_AB     10'h1e0
`define DAIRM_OFF_CONV3_DATA_CD     10'h1e4
`define DAIRM_OFF_CONV3_STATUS      10'h1e8
`define DAIRM_OFF_CONV3_MODE        10'h1ec
`define DAIRM_OFF_CONV4_CONFIG      10'h1f8
`define DAIRM_OFF_CONV4_CORR_A      10'h200
`define DAIRM_OFF_CONV4_CORR_B      10'h204
`define DAIRM_OFF_CONV4_CORR_C      10'h208
`define DAIRM_OFF_CONV4_CORR_D      10'h20c
`define DAIRM_OFF_CONV4_DATA_AB     10'h210
`define DAIRM_OFF_CONV4_DATA_CD     10'h214
`define DAIRM_OFF_CONV4_STATUS      10'h218
`define DAIRM_OFF_CONV4_MODE        10'h21c
`define DAIRM_OFF_SEQ_CONTROL       10'h2e8
`define DAIRM_OFF_SEQ_STATUS        10'h2ec
`define DAIRM_OFF_SEQ_CONV_TOTAL    10'h2f4
`define DAIRM_OFF_SEQ_CONV_COUNT    10'h2f8
`define DAIRM_OFF_SEQ_QUEUE_LEVEL   10'h2fc
`define DAIRM_OFF_SEQ_BUF_BASE      10'h308
`define DAIRM_OFF_SEQ_BUF_LENGTH    10'h30c
`define DAIRM_OFF_SEQ_BUF_NEXT      10'h310
`define DAIRM_OFF_CONV_CLOCK1       10'h320
`define DAIRM_OFF_CONV_CLOCK2       10'h324
`define DAIRM_OFF_FRAME_TRIG_1      10'h32c
`define DAIRM_OFF_FRAME_TRIG_2      10'h330
`define DAIRM_OFF_SIG_GEN_ENABLE    10'h33c
`define DAIRM_OFF_SIG_OUT_DRIVE     10'h340
`define DAIRM_OFF_SIG_SOURCE_SEL    10'h344
`define DAIRM_OFF_FRAME_TIMER       10'h348
`define DAIRM_OFF_PIN_INPUT         10'h354
`define DAIRM_OFF_PIN_DEBOUNCE      10'h358
`define DAIRM_OFF_PIN_OUTPUT        10'h35c
`define DAIRM_OFF_PIN_OUTPUT_EN     10'h360
`define DAIRM_OFF_IRQ_ENABLE        10'h36c
`define DAIRM_OFF_ERR_IRQ_ENABLE    10'h370
`define DAIRM_OFF_PIN_RISE_EN       10'h374
`define DAIRM_OFF_PIN_FALL_EN       10'h378
`define DAIRM_OFF_IRQ_STATUS        10'h384
`define DAIRM_OFF_ERR_IRQ_STATUS    10'h388
`define DAIRM_OFF_PIN_IRQ_STATUS    10'h38c

// ****************************************************************
// Storage window, fields and reset values
// ****************************************************************
`define DAIRM_MEM_FIRST_WORD        8'h6d
`define DAIRM_MEM_WORDS             119
`define DAIRM_SEQ_START_BIT         0
`define DAIRM_RW_RESET              32'h0000_0000
`define DAIRM_STATUS_RESET          32'h0000_0000
`define DAIRM_RSV_READ              32'h0000_0000
`define DAIRM_PIN_COUNT             8

`endif

// *** verilog/dairm_pkg.sv ***
// Types shared by the upper register map
`default_nettype none
package dairm_pkg;
   typedef enum logic [2:0] {
      DAIRM_RSV,
      DAIRM_RW,
      DAIRM_RO,
      DAIRM_RC,
      DAIRM_SEQ
   } dairm_access_e;
endpackage
`default_nettype wire

// *** testbench/dairm_register_map_sva.sv ***
// Concurrent checks on the upper register map host port and access kinds
`default_nettype none
module dairm_register_map_sva import dairm_pkg::*; #(
   parameter int PIN_COUNT = 8
) (
   input wire logic                 clk_i,
   input wire logic                 rst_b_i,
   input wire logic [9:0]           bus_addr_i,
   input wire logic [3:0]           bus_be_i,
   input wire logic                 bus_wr_i,
   input wire logic                 bus_rd_i,
   input wire logic [31:0]          bus_wdata_i,
   input wire logic [31:0]          bus_rdata_o,
   input wire logic                 bus_ack_o,
   input wire logic [31:0]          irq_event_i,
   input wire logic [31:0]          error_event_i,
   input wire logic                 seq_start_clear_i,
   input wire logic                 seq_start_o,
   input wire logic [31:0]          seq_control_o,
   input wire logic [31:0]          irq_status_o,
   input wire logic [31:0]          error_irq_status_o,
   input wire logic [PIN_COUNT-1:0] digital_pin_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   wire logic                 strobe = bus_wr_i || bus_rd_i;
   wire logic                 wr_all = bus_wr_i && bus_be_i == 4'hf;
   wire logic                 sw_set = bus_wr_i && bus_addr_i == 10'h2e8 && bus_be_i[0]
                                       && bus_wdata_i[0];
   wire logic [PIN_COUNT-1:0] wd_low = bus_wdata_i[PIN_COUNT-1:0];
   // ****************************************************************
   // Host port and access kinds
   // ****************************************************************
   AST_ACK_NEXT: assert property (strobe |=> bus_ack_o)
      else $error("no ack one cycle after a strobe");
   AST_ACK_CAUSE: assert property (bus_ack_o |-> $past(strobe))
      else $error("ack without a strobe");
   AST_RDATA_HOLD: assert property (!bus_rd_i |=> $stable(bus_rdata_o))
      else $error("read data moved without a read");
   AST_PIN_WRITE: assert property (wr_all && bus_addr_i == 10'h35c |=> digital_pin_o == $past(wd_low))
      else $error("pin output word not updated by write");
   AST_STAT_CLEAR: assert property (wr_all && bus_addr_i == 10'h384 |=>
      irq_status_o == (($past(irq_status_o) & ~$past(bus_wdata_i)) | $past(irq_event_i)))
      else $error("status clear by writing one wrong");
   AST_STAT_HOLD: assert property (!(bus_wr_i && bus_addr_i == 10'h388) |=>
      error_irq_status_o == ($past(error_irq_status_o) | $past(error_event_i)))
      else $error("error status changed without write or event");
   AST_START_SET: assert property (sw_set |=> seq_start_o)
      else $error("start flag not set by writing one");
   AST_START_KEEP: assert property (seq_start_o && !seq_start_clear_i |=> seq_start_o)
      else $error("start flag cleared by software");
   AST_START_CLEAR: assert property (seq_start_clear_i && !sw_set |=> !seq_start_o)
      else $error("start flag not cleared by hardware");
   AST_RD_STATUS: assert property (bus_rd_i && bus_addr_i == 10'h384 |=>
      bus_rdata_o == $past(irq_status_o))
      else $error("status offset read wrong word");
   AST_RD_CONTROL: assert property (bus_rd_i && bus_addr_i == 10'h2e8 |=>
      bus_rdata_o == $past(seq_control_o))
      else $error("sequencer control offset read wrong word");
   COV_SET: cover property (sw_set);
   COV_EVENT_CLEAR: cover property (wr_all && bus_addr_i == 10'h384 && |irq_event_i);
   COV_HW_CLEAR: cover property (seq_start_clear_i && seq_start_o);
endmodule // dairm_register_map_sva

bind dairm_register_map dairm_register_map_sva #(.PIN_COUNT(PIN_COUNT)) u_sva (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .bus_addr_i(bus_addr_i), .bus_be_i(bus_be_i),
   .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i),
   .bus_rdata_o(bus_rdata_o), .bus_ack_o(bus_ack_o), .irq_event_i(irq_event_i),
   .error_event_i(error_event_i), .seq_start_clear_i(seq_start_clear_i),
   .seq_start_o(seq_start_o), .seq_control_o(seq_control_o), .irq_status_o(irq_status_o),
   .error_irq_status_o(error_irq_status_o), .digital_pin_o(digital_pin_o));
`default_nettype wire

// *** testbench/dairm_host_model.sv ***
// Host model issuing strobe and ack accesses into base region zero
`default_nettype none
module dairm_host_model (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] rdata_i,
   output logic      [9:0]  addr_o,
   output logic      [3:0]  be_o,
   output logic             wr_o,
   output logic             rd_o,
   output logic      [31:0] wdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      addr_o = 10'h3ff;
      be_o = 4'h0;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 32'h0;
   end
   task automatic access(input logic wr, input logic [9:0] a, input logic [3:0] be,
                         input logic [31:0] d, output logic ack, output logic [31:0] q);
      @(negedge clk_i);
      addr_o = a;
      be_o = be;
      wdata_o = d;
      wr_o = wr;
      rd_o = !wr;
      @(negedge clk_i);
      ack = ack_i;
      q = rdata_i;
      wr_o = 1'b0;
      rd_o = 1'b0;
      // Released lines carry junk so stale values cannot pass
      addr_o = ~a;
      wdata_o = ~d;
   endtask
endmodule // dairm_host_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the upper register map
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk;
   logic        rst_b;
   logic [9:0]  addr;
   logic [3:0]  be;
   logic        wr;
   logic        rd;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        ack;
   logic [31:0] ro_val;
   logic [31:0] irq_ev;
   logic [31:0] err_ev;
   logic        start_clr;
   logic        start;
   logic [31:0] seq_ctl;
   logic [31:0] irq_st;
   logic [31:0] err_st;
   logic [31:0] pin_st;
   logic [9:0]  rw_sel;
   logic [31:0] rw_word;
   logic [7:0]  pin_in;
   logic [7:0]  pin_o;
   logic [7:0]  pin_oe;
   int          error_cnt = 0;
   int          checks_done = 0;
   int          cyc = 0;
   logic [9:0]  rw_off [33] = '{10'h1b4, 10'h1bc, 10'h1c8, 10'h1d0, 10'h1d4, 10'h1d8, 10'h1dc,
      10'h1e0, 10'h1e4, 10'h1ec, 10'h1f8, 10'h200, 10'h204, 10'h208, 10'h20c, 10'h210, 10'h214,
      10'h21c, 10'h2f4, 10'h308, 10'h30c, 10'h320, 10'h324, 10'h32c, 10'h330, 10'h33c, 10'h340,
      10'h344, 10'h358, 10'h36c, 10'h370, 10'h374, 10'h378};
   logic [9:0]  ro_off [8] = '{10'h1b8, 10'h1e8, 10'h218, 10'h2ec, 10'h2f8, 10'h2fc, 10'h310,
      10'h348};
   logic [9:0]  rsv_off [12] = '{10'h1c0, 10'h1c4, 10'h1cc, 10'h1f0, 10'h228, 10'h2e4, 10'h2f0,
      10'h300, 10'h31c, 10'h34c, 10'h37c, 10'h394};

   dairm_register_map #(.PIN_COUNT(8), .HAS_OUT_CONV(1'b1)) u_dut (
      .clk_i(clk), .rst_b_i(rst_b), .bus_addr_i(addr), .bus_be_i(be), .bus_wr_i(wr),
      .bus_rd_i(rd), .bus_wdata_i(wdata), .bus_rdata_o(rdata), .bus_ack_o(ack),
      .conv2_status_i(ro_val + 32'h1), .conv3_status_i(ro_val + 32'h2),
      .conv4_status_i(ro_val + 32'h3), .seq_status_i(ro_val + 32'h4),
      .seq_conv_count_i(ro_val + 32'h5), .seq_queue_level_i(ro_val + 32'h6),
      .seq_buffer_next_i(ro_val + 32'h7), .frame_timer_i(ro_val + 32'h8),
      .irq_event_i(irq_ev), .error_event_i(err_ev), .seq_start_clear_i(start_clr),
      .seq_start_o(start), .seq_control_o(seq_ctl), .irq_status_o(irq_st),
      .error_irq_status_o(err_st), .pin_irq_status_o(pin_st), .rw_sel_i(rw_sel),
      .rw_word_o(rw_word), .digital_pin_i(pin_in), .digital_pin_o(pin_o),
      .digital_pin_oe_o(pin_oe));
   dairm_host_model u_host (.clk_i(clk), .ack_i(ack), .rdata_i(rdata), .addr_o(addr),
      .be_o(be), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [9:0] a, input logic [3:0] b, input logic [31:0] d);
      logic        k;
      logic [31:0] q;
      u_host.access(1'b1, a, b, d, k, q);
      chk({31'h0, k}, 32'h1);
   endtask
   task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
      logic        k;
      logic [31:0] q;
      u_host.access(1'b0, a, 4'h0, 32'h0, k, q);
      chk({31'h0, k}, 32'h1);
      chk(q, exp);
   endtask
   function automatic logic [31:0] pat(input logic [9:0] a);
      return {a, ~a, 12'h5a3};
   endfunction

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic test_rw();
      for (int i = 0; i < 33; i++) begin
         rdc(rw_off[i], 32'h0);
         wr_reg(rw_off[i], 4'hf, pat(rw_off[i]));
      end
      for (int i = 0; i < 33; i++) begin
         rdc(rw_off[i], pat(rw_off[i]));
         rw_sel = rw_off[i];
         @(negedge clk);
         chk(rw_word, pat(rw_off[i]));
      end
      wr_reg(10'h36c, 4'h5, 32'hffff_ffff);
      rdc(10'h36c, (pat(10'h36c) & 32'hff00_ff00) | 32'h00ff_00ff);
   endtask
   task automatic test_ro_rsv();
      ro_val = 32'h3c00_1000;
      for (int i = 0; i < 8; i++) begin
         wr_reg(ro_off[i], 4'hf, 32'h0);
         rdc(ro_off[i], 32'h3c00_1001 + 32'(i));
      end
      for (int i = 0; i < 12; i++) begin
         wr_reg(rsv_off[i], 4'hf, 32'hffff_ffff);
         rdc(rsv_off[i], 32'h0);
      end
      rdc(10'h1bc, pat(10'h1bc));
   endtask
   task automatic test_rc();
      @(negedge clk);
      irq_ev = 32'h0000_00f1;
      err_ev = 32'h8000_0003;
      @(negedge clk);
      irq_ev = 32'h0;
      err_ev = 32'h0;
      rdc(10'h384, 32'h0000_00f1);
      rdc(10'h388, 32'h8000_0003);
      wr_reg(10'h384, 4'hf, 32'h0000_0011);
      rdc(10'h384, 32'h0000_00e0);
      wr_reg(10'h388, 4'hf, 32'h0);
      rdc(10'h388, 32'h8000_0003);
      wr_reg(10'h388, 4'h1, 32'hffff_ffff);
      chk(err_st, 32'h8000_0000);
      // Event in the clearing cycle must win
      fork
         wr_reg(10'h384, 4'hf, 32'h0000_0020);
         begin
            @(negedge clk);
            irq_ev = 32'h0000_0020;
            @(negedge clk);
            irq_ev = 32'h0;
         end
      join
      chk(irq_st, 32'h0000_00e0);
   endtask
   task automatic test_rs();
      wr_reg(10'h2e8, 4'hf, 32'h0000_0a01);
      chk({31'h0, start}, 32'h1);
      rdc(10'h2e8, 32'h0000_0a01);
      wr_reg(10'h2e8, 4'hf, 32'h0000_0a00);
      chk({31'h0, start}, 32'h1);
      start_clr = 1'b1;
      @(negedge clk);
      start_clr = 1'b0;
      chk({31'h0, start}, 32'h0);
      chk(seq_ctl, 32'h0000_0a00);
   endtask
   task automatic test_pins();
      wr_reg(10'h358, 4'hf, 32'h0);
      wr_reg(10'h360, 4'hf, 32'h0000_000f);
      wr_reg(10'h35c, 4'hf, 32'h0000_00a5);
      chk({16'h0, pin_oe, pin_o}, 32'h0000_0fa5);
      wr_reg(10'h374, 4'hf, 32'h1);
      wr_reg(10'h378, 4'hf, 32'h2);
      pin_in = 8'h03;
      repeat (6) @(negedge clk);
      rdc(10'h354, 32'h3);
      rdc(10'h38c, 32'h1);
      pin_in = 8'h00;
      repeat (6) @(negedge clk);
      chk(pin_st, 32'h3);
      wr_reg(10'h38c, 4'hf, 32'h1);
      rdc(10'h38c, 32'h2);
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         complete_run();
      end
   end
   initial begin
      rst_b = 1'b0;
      ro_val = 32'h0;
      irq_ev = 32'h0;
      err_ev = 32'h0;
      start_clr = 1'b0;
      rw_sel = 10'h0;
      pin_in = 8'h00;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      chk(irq_st | err_st | pin_st | seq_ctl, 32'h0);
      test_rw();
      test_ro_rsv();
      test_rc();
      test_rs();
      test_pins();
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
